/* File: pwm_auto_reload_timer.sv */
// Purpose: 8-bit auto-reload timer with four pwm channels
// Assumes: sleep inputs come from logic on clk_sys
// Notes:   extClk is an asynchronous pin, synchronised here
//
// Operation
// - 8-bit counter steps on each prescaled tick
// - counter access register reads and writes live
// - overflow reloads counter, prescaler untouched
// - 7-bit prescaler, tap chosen by divide field
// - input is cpu clock or external clock
// - run enable low freezes prescaler and counter
// - reset clears counter, prescaler, selects cpu
// - force reload or counter write clears prescaler
// - prescaler has no register of its own
// - hidden compare values load at overflow only
// - enabled channel drives its pin push-pull
// - all channels share one reload period
// - overflow sets pins per channel polarity
// - compare match returns pin opposite level
// - reload zero gives full 1/256 resolution
// - pwm generation stops in deep sleep
// - overflow sets flag, enabled flag raises irq
// - external edges counted on through overflow and reload
// - interrupt wakes chip from either sleep
// - reading control/status clears overflow flag
// - force reload reads back as zero
// - polarity zero high at or below compare
// - deep sleep: registers frozen, ext counting continues
`timescale 1ns/1ns
module pwm_auto_reload_timer
   import art_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wrData,
   input  wire logic              wrStb,
   input  wire logic              rdStb,
   output logic      [DATA_W-1:0] rdData,
   input  wire logic              extClk,
   input  wire logic              lightSleep,
   input  wire logic              deepSleep,
   output logic      [NUM_CH-1:0] pwmOut,
   output logic      [NUM_CH-1:0] pwmOe,
   output logic                   irqReq,
   output logic                   wakeReq
);

   ////////////////////////////////////////////////////////////////
   // state
   logic              extSync1_q;
   logic              extSync2_q;
   logic              extPrev_q;
   logic              ext_clock_select_q;
   logic [2:0]        cc_q;
   logic              tce_q;
   logic              oie_q;
   logic              ovf_q;
   logic [7:0]        arr_q;
   logic [NUM_CH-1:0] oe_q;
   logic [NUM_CH-1:0] pol_q;
   logic [7:0]        dcr_q [NUM_CH];
   logic [7:0]        cmp_q [NUM_CH];
   logic [7:0]        cnt_q;
   logic [6:0]        presc_q;
   logic [7:0]        rdData_q;
   logic [NUM_CH-1:0] pwmOut_q;
   logic [NUM_CH-1:0] pwmOe_q;
   logic              irq_q;
   logic              wake_q;

   logic              regWrEn;
   logic              csrWr;
   logic              carWr;
   logic              fcrlWr;
   logic              csrRd;
   logic              inTick;
   logic              runOk;
   logic [6:0]        tapMask;
   logic              cntTick;
   logic              wrap;
   logic [3:0]        dcrIdx;

   ////////////////////////////////////////////////////////////////
   // external clock pin synchroniser and edge detect
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         extSync1_q <= 1'b0;
         extSync2_q <= 1'b0;
         extPrev_q  <= 1'b0;
      end else begin
         extSync1_q <= extClk;
         extSync2_q <= extSync1_q;
         extPrev_q  <= extSync2_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // decode
   // control registers frozen in deep sleep
   assign regWrEn = wrStb && !deepSleep;
   assign csrWr   = regWrEn && (addr == OFS_CSR);
   assign carWr   = regWrEn && (addr == OFS_CAR);
   // reload forced only when run enable set in same write
   assign fcrlWr  = csrWr && wrData[CSR_FORCE_RELOAD]
                    && wrData[CSR_TCE];
   assign csrRd   = rdStb && (addr == OFS_CSR);
   assign dcrIdx  = addr - OFS_DCR0;

   ////////////////////////////////////////////////////////////////
   // prescaler input and tap selection
   assign inTick  = ext_clock_select_q ? (extSync2_q && !extPrev_q)
                           : 1'b1;
   // cpu clock source stops in deep sleep, ext keeps going
   assign runOk   = tce_q && (!deepSleep || ext_clock_select_q);
   assign tapMask = 7'((8'h01 << cc_q) - 8'h01);
   assign cntTick = runOk && inTick
                    && ((presc_q & tapMask) == tapMask);
   // a software load in the same cycle preempts the wrap
   assign wrap    = cntTick && (cnt_q == CNT_TOP)
                    && !carWr && !fcrlWr;

   ////////////////////////////////////////////////////////////////
   // prescaler, not mapped to any register, cleared by counter write or force reload
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         presc_q <= RST_PRESC;
      end else if (carWr || fcrlWr) begin
         presc_q <= RST_PRESC;
      end else if (runOk && inTick) begin
         presc_q <= presc_q + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////
   // counter
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt_q <= RST_REG;
      end else if (carWr) begin
         cnt_q <= wrData;
      end else if (fcrlWr) begin
         cnt_q <= arr_q;
      end else if (wrap) begin
         cnt_q <= arr_q;
      end else if (cntTick) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////
   // control/status fields
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ext_clock_select_q <= 1'b0;
         cc_q   <= RST_CC;
         tce_q  <= 1'b0;
         oie_q  <= 1'b0;
      end else if (csrWr) begin
         ext_clock_select_q <= wrData[CSR_EXT_CLOCK_SELECT];
         cc_q   <= wrData[CSR_CC_HI:CSR_CC_LO];
         tce_q  <= wrData[CSR_TCE];
         oie_q  <= wrData[CSR_OIE];
      end
   end

   // set wins over the clear by read
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ovf_q <= 1'b0;
      end else if (wrap) begin
         ovf_q <= 1'b1;
      end else if (csrRd) begin
         ovf_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         arr_q <= RST_REG;
      end else if (regWrEn && addr == OFS_ARR) begin
         arr_q <= wrData;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         oe_q  <= RST_NIBBLE;
         pol_q <= RST_NIBBLE;
      end else if (regWrEn && addr == OFS_CHANNEL_CONTROL_REG) begin
         oe_q  <= wrData[CHANNEL_CONTROL_REG_OE_LO +: NUM_CH];
         pol_q <= wrData[CHANNEL_CONTROL_REG_OP_LO +: NUM_CH];
      end
   end

   ////////////////////////////////////////////////////////////////
   // per channel duty, compare and output
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : gCh
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               dcr_q[ch] <= RST_REG;
            end else if (regWrEn && addr >= OFS_DCR0
                         && addr <= OFS_DCR3
                         && dcrIdx == 4'(ch)) begin
               dcr_q[ch] <= wrData;
            end
         end

         // double buffer avoids mid-period glitches
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               cmp_q[ch] <= RST_REG;
            end else if (wrap) begin
               cmp_q[ch] <= dcr_q[ch];
            end
         end

         // duty only visible while compare at or above reload
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               pwmOut_q[ch] <= 1'b0;
               pwmOe_q[ch]  <= 1'b0;
            end else if (!deepSleep) begin
               pwmOe_q[ch]  <= oe_q[ch];
               pwmOut_q[ch] <= oe_q[ch]
                  && ((cnt_q <= cmp_q[ch])
                      ^ pol_q[ch]);
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // interrupt request and wake
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         irq_q  <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         irq_q  <= ovf_q && oie_q;
         wake_q <= ovf_q && oie_q
                   && (lightSleep || deepSleep);
      end
   end

   ////////////////////////////////////////////////////////////////
   // read port, answer one cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdData_q <= RST_REG;
      end else if (rdStb) begin
         unique case (addr)
            OFS_CSR:   rdData_q <= {ext_clock_select_q, cc_q, tce_q,
                                    1'b0, oie_q, ovf_q};
            OFS_CAR:   rdData_q <= cnt_q;
            OFS_ARR:   rdData_q <= arr_q;
            OFS_CHANNEL_CONTROL_REG: rdData_q <= {oe_q, pol_q};
            4'h4, 4'h5, 4'h6, 4'h7:
                       rdData_q <= dcr_q[dcrIdx[1:0]];
            default:   rdData_q <= RST_REG;
         endcase
      end else begin
         rdData_q <= RST_REG;
      end
   end

   assign rdData  = rdData_q;
   assign pwmOut  = pwmOut_q;
   assign pwmOe   = pwmOe_q;
   assign irqReq  = irq_q;
   assign wakeReq = wake_q;

   ////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   chk_wrap_reload: assert property (
      wrap |=> cnt_q == $past(arr_q))
      else $error("counter not reloaded at overflow");

   chk_run_freeze: assert property (
      (!tce_q && !carWr && !fcrlWr)
      |=> $stable(cnt_q) && $stable(presc_q))
      else $error("counter moved while stopped");

   chk_car_write: assert property (
      carWr |=> presc_q == 7'h00
                && cnt_q == $past(wrData))
      else $error("counter write did not load");

   chk_ovf_set: assert property (
      wrap |=> ovf_q ##1 (irqReq || !$past(oie_q)))
      else $error("overflow flag or irq missing");

   chk_ovf_clear: assert property (
      (csrRd && !wrap) |=> !ovf_q)
      else $error("flag not cleared by read");

   chk_cmp_load: assert property (
      !wrap |=> cmp_q[0] == $past(cmp_q[0]))
      else $error("compare changed outside overflow");

   chk_force_reload_read: assert property (
      csrRd |=> rdData[CSR_FORCE_RELOAD] == 1'b0
                && rdData[CSR_OVF] == $past(ovf_q))
      else $error("control/status read wrong");

   chk_pwm_level: assert property (
      (oe_q[0] && !deepSleep) |=> pwmOut[0] ==
      (($past(cnt_q) <= $past(cmp_q[0])) ^ $past(pol_q[0])))
      else $error("pwm level wrong");

   chk_full_rate: assert property (
      (runOk && !ext_clock_select_q && cc_q == 3'h0 && !carWr
       && !fcrlWr && cnt_q != CNT_TOP)
      |=> cnt_q == $past(cnt_q) + 8'h01)
      else $error("counter missed a tick");

   chk_sleep_hold: assert property (
      deepSleep |=> $stable(pwmOut))
      else $error("pwm moved in deep sleep");

   // writes are dropped, not deferred, while in deep sleep
   chk_sleep_regs: assert property (
      (deepSleep && wrStb) |=> $stable(arr_q) && $stable(oe_q))
      else $error("register written in deep sleep");

   chk_wake_req: assert property (
      (ovf_q && oie_q && (lightSleep || deepSleep)) |=> wakeReq)
      else $error("wake request missing");

   cov_light_wake: cover property (lightSleep && wakeReq);
   cov_overflow: cover property (wrap ##1 irqReq);
   cov_ext_count: cover property (ext_clock_select_q && cntTick);
   cov_wake: cover property (deepSleep && wrap ##[1:3] wakeReq);
endmodule : pwm_auto_reload_timer

/* File: art_pkg.sv */
// Purpose: constants shared by the auto-reload pwm timer
// Assumes: 8-bit register port, word index addressing
// Notes:   offsets are register indices on the plain port
package art_pkg;
   localparam int          NUM_CH      = 4;
   localparam int          ADDR_W      = 4;
   localparam int          DATA_W      = 8;
   localparam int          PRESC_W     = 7;
   // register offsets
   localparam logic [3:0]  OFS_CSR     = 4'h0;
   localparam logic [3:0]  OFS_CAR     = 4'h1;
   localparam logic [3:0]  OFS_ARR     = 4'h2;
   localparam logic [3:0]  OFS_CHANNEL_CONTROL_REG   = 4'h3;
   localparam logic [3:0]  OFS_DCR0    = 4'h4;
   localparam logic [3:0]  OFS_DCR3    = 4'h7;
   // control/status field positions
   localparam int          CSR_EXT_CLOCK_SELECT    = 7;
   localparam int          CSR_CC_HI   = 6;
   localparam int          CSR_CC_LO   = 4;
   localparam int          CSR_TCE     = 3;
   localparam int          CSR_FORCE_RELOAD    = 2;
   localparam int          CSR_OIE     = 1;
   localparam int          CSR_OVF     = 0;
   // channel control field positions
   localparam int          CHANNEL_CONTROL_REG_OE_LO = 4;
   localparam int          CHANNEL_CONTROL_REG_OP_LO = 0;
   // reset values and counter top
   localparam logic [7:0]  RST_REG     = 8'h00;
   localparam logic [6:0]  RST_PRESC   = 7'h00;
   localparam logic [2:0]  RST_CC      = 3'h0;
   localparam logic [3:0]  RST_NIBBLE  = 4'h0;
   localparam logic [7:0]  CNT_TOP     = 8'hff;
endpackage : art_pkg

/* File: pwm_ext_model.sv */
// Purpose: far side model, pwm pins and external count clock
// Assumes: pins are sampled on clk_sys
// Notes:   extClk idles low, a quiet pin between bursts
`timescale 1ns/1ns
module pwm_ext_model
   import art_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic [NUM_CH-1:0] pwmOut,
   input  wire logic [NUM_CH-1:0] pwmOe,
   output logic                   extClk
);
   int highCnt [NUM_CH];
   initial extClk = 1'b0;
   ////////////////////////////////////////////////////////////////////
   // slow edges, well above the synchroniser's needs
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk_sys) extClk <= 1'b1;
         repeat (4) @(posedge clk_sys);
         extClk <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
   endtask : pulse
   // pin high only counts while driven
   task automatic measure(input int n);
      for (int c = 0; c < NUM_CH; c++) highCnt[c] = 0;
      repeat (n) begin
         @(posedge clk_sys) #1;
         for (int c = 0; c < NUM_CH; c++)
            if (pwmOe[c] === 1'b1 && pwmOut[c] === 1'b1) highCnt[c]++;
      end
   endtask : measure
endmodule : pwm_ext_model

/* File: tb_pwm_auto_reload_timer.sv */
// Purpose: self-checking bench for the auto-reload pwm timer
// Assumes: plain register port, read data one cycle late
// Notes:   wake is checked in deep sleep and in light sleep
`timescale 1ns/1ns
module tb_pwm_auto_reload_timer
   import art_pkg::*;
;
   logic              clk_sys, rst_n, wrStb, rdStb;
   logic              lightSleep, deepSleep, extClk, irqReq, wakeReq;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wrData, rdData, v;
   logic [NUM_CH-1:0] pwmOut, pwmOe, p;
   int                nFail, testsRun;
   pwm_auto_reload_timer u_pwm_auto_reload_timer (.clk_sys(clk_sys),
      .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
      .rdStb(rdStb), .rdData(rdData), .extClk(extClk),
      .lightSleep(lightSleep), .deepSleep(deepSleep), .pwmOut(pwmOut),
      .pwmOe(pwmOe), .irqReq(irqReq), .wakeReq(wakeReq));
   pwm_ext_model u_pwm_ext_model (.clk_sys(clk_sys), .pwmOut(pwmOut),
      .pwmOe(pwmOe), .extClk(extClk));
   ////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic conclude;
      if (nFail == 0 && testsRun > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   task automatic chk(input logic [7:0] got, exp, input string m);
      testsRun++;
      if (got !== exp) begin
         nFail++;
         $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys) begin
         addr <= a; wrData <= d; wrStb <= 1'b1;
      end
      @(posedge clk_sys) wrStb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys) begin
         addr <= a; rdStb <= 1'b1;
      end
      @(posedge clk_sys) rdStb <= 1'b0;
      #1 d = rdData;
   endtask : rd
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(OFS_CSR, v); chk(v, 8'h00, "csr rst");
      rd(OFS_CAR, v); chk(v, 8'h00, "cnt rst");
      chk({4'h0, pwmOe}, 8'h00, "oe rst");
      rd(4'h8, v); chk(v, 8'h00, "unmapped");
   endtask : t_reset
   task automatic t_frozen;
      wr(OFS_CAR, 8'h33);
      repeat (10) @(posedge clk_sys);
      rd(OFS_CAR, v); chk(v, 8'h33, "frozen");
   endtask : t_frozen
   // overflow raises flag and irq, reads after the stop write clear the flag
   task automatic t_overflow;
      wr(OFS_ARR, 8'hfe); wr(OFS_CAR, 8'h10);
      wr(OFS_CSR, 8'h0e);
      repeat (6) @(posedge clk_sys);
      chk({7'h0, irqReq}, 8'h01, "irq");
      rd(OFS_CSR, v); chk(v, 8'h0b, "ovf set");
      rd(OFS_CAR, v); chk({7'h0, v >= 8'hfe}, 8'h01, "reload");
      wr(OFS_CSR, 8'h02); rd(OFS_CSR, v); rd(OFS_CSR, v);
      chk(v, 8'h02, "ovf clr");
      repeat (2) @(posedge clk_sys);
      chk({7'h0, irqReq}, 8'h00, "irq clr");
   endtask : t_overflow
   task automatic t_prescale;
      for (int k = 0; k < 4; k++) begin
         wr(OFS_CSR, 8'h00); wr(OFS_CAR, 8'h00);
         wr(OFS_CSR, {1'b0, 3'(k), 4'h8});
         repeat (8 << k) @(posedge clk_sys);
         wr(OFS_CSR, 8'h00); rd(OFS_CAR, v);
         // two more input ticks pass while the stop write lands
         chk(v, 8'(((8 << k) + 2) >> k), "div");
      end
   endtask : t_prescale
   task automatic t_ext;
      wr(OFS_ARR, 8'hfd); wr(OFS_CAR, 8'hfd); wr(OFS_CSR, 8'h88);
      rd(OFS_CSR, v); repeat (20) @(posedge clk_sys);
      rd(OFS_CAR, v); chk(v, 8'hfd, "no cpu");
      u_pwm_ext_model.pulse(2); repeat (6) @(posedge clk_sys);
      rd(OFS_CSR, v); chk(v, 8'h88, "2 ev");
      u_pwm_ext_model.pulse(1); repeat (6) @(posedge clk_sys);
      rd(OFS_CSR, v); chk(v, 8'h89, "3 ev");
      rd(OFS_CAR, v); chk(v, 8'hfd, "ev rld");
   endtask : t_ext
   // period 16: ch0 high f0..f8, ch1 inverted high f5..ff
   task automatic t_pwm;
      wr(OFS_CSR, 8'h00); wr(OFS_ARR, 8'hf0);
      wr(OFS_DCR0, 8'hf8); wr(OFS_DCR0 + 4'h1, 8'hf4);
      wr(OFS_CHANNEL_CONTROL_REG, 8'h32); wr(OFS_CAR, 8'hf0); wr(OFS_CSR, 8'h0a);
      repeat (40) @(posedge clk_sys);
      chk({4'h0, pwmOe}, 8'h03, "oe");
      u_pwm_ext_model.measure(64);
      chk(8'(u_pwm_ext_model.highCnt[0]), 8'd36, "ch0");
      chk(8'(u_pwm_ext_model.highCnt[1]), 8'd44, "ch1");
      chk(8'(u_pwm_ext_model.highCnt[2]), 8'd0, "ch2");
   endtask : t_pwm
   task automatic t_sleep;
      @(posedge clk_sys) deepSleep <= 1'b1;
      repeat (3) @(posedge clk_sys);
      p = pwmOut;
      wr(OFS_ARR, 8'h55); repeat (16) @(posedge clk_sys);
      chk({4'h0, pwmOut}, {4'h0, p}, "frozen pwm");
      chk({7'h0, wakeReq}, 8'h01, "wake");
      @(posedge clk_sys) deepSleep <= 1'b0;
      rd(OFS_ARR, v); chk(v, 8'hf0, "sleep wr");
      chk({7'h0, wakeReq}, 8'h00, "awake");
      @(posedge clk_sys) lightSleep <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk({7'h0, wakeReq}, 8'h01, "light wake");
      @(posedge clk_sys) lightSleep <= 1'b0;
   endtask : t_sleep
   // reload zero: 256-step period, 0% by polarity on ch2
   task automatic t_full;
      wr(OFS_CSR, 8'h00); wr(OFS_ARR, 8'h00); wr(OFS_CAR, 8'hff);
      wr(OFS_DCR0 + 4'h2, 8'hff); wr(OFS_DCR3, 8'h80);
      wr(OFS_CHANNEL_CONTROL_REG, 8'hc4); wr(OFS_CSR, 8'h08);
      repeat (4) @(posedge clk_sys);
      u_pwm_ext_model.measure(256);
      chk(8'(u_pwm_ext_model.highCnt[2]), 8'd0, "zero duty");
      chk(8'(u_pwm_ext_model.highCnt[3]), 8'h81, "fine duty");
   endtask : t_full
   ////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      nFail++;
      $display("FAIL %0t watchdog", $time);
      conclude();
   end
   initial begin
      rst_n = 1'b0; addr = '0; wrData = '0; wrStb = 1'b0; rdStb = 1'b0;
      lightSleep = 1'b0; deepSleep = 1'b0; nFail = 0; testsRun = 0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset(); t_frozen(); t_overflow(); t_prescale();
      t_ext(); t_pwm(); t_sleep(); t_full();
      conclude();
   end
endmodule : tb_pwm_auto_reload_timer
